//--- tmh_top.sv
// two 8-bit compare timers with register access and count clock selection
// Summary of operation
// - period match raises interrupt, toggles output
// - period always used; duty only pwm/carrier
// - pwm duty match toggles output, no interrupt
// - carrier duty match interrupts and clears counter
// - running duty write buffered until old match
// - write colliding with match keeps active duty
// - bit 7 runs; clearing stops, zeroes counter
// - timer zero clock select table, event input
// - timer one clock select table, low-speed clock
// - bits 3-2 select interval, pwm, carrier (carrier on timer one only)
// - bit 1 idle level, bit 0 output enable
// - event counter pin need not be enabled
// - pwm compares period first, then alternates
// - stopping returns interrupt and output to default
`timescale 1ns/10ps
`include "tmh_regs.svh"

module tmh_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic lso_clk,
    input wire logic event_counter_out,
    output logic timer_output_pin0,
    output logic timer_output_pin1,
    output logic timer_interrupt_request0,
    output logic timer_interrupt_request1
);

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] mode_q [2];
    logic [7:0] mode_d [2];
    logic [7:0] period_q [2];
    logic [7:0] period_d [2];
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] duty_rb [2];
    logic [1:0] duty_wr;
    logic [1:0] irq;
    logic [1:0] tout;
    logic [1:0] tick;

    always_comb begin
        mode_d = mode_q;
        period_d = period_q;
        duty_wr = 2'b00;
        if (reg_wr) begin
            unique case (reg_addr)
                `TMH_ADDR_MODE0: mode_d[0] = reg_wdata;
                `TMH_ADDR_MODE1: mode_d[1] = reg_wdata;
                `TMH_ADDR_PERIOD0: period_d[0] = reg_wdata;
                `TMH_ADDR_PERIOD1: period_d[1] = reg_wdata;
                `TMH_ADDR_DUTY0: duty_wr[0] = 1'b1;
                `TMH_ADDR_DUTY1: duty_wr[1] = 1'b1;
                default: ;
            endcase
        end
    end

    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            unique case (reg_addr)
                `TMH_ADDR_MODE0: rdata_d = mode_q[0];
                `TMH_ADDR_MODE1: rdata_d = mode_q[1];
                `TMH_ADDR_PERIOD0: rdata_d = period_q[0];
                `TMH_ADDR_PERIOD1: rdata_d = period_q[1];
                `TMH_ADDR_DUTY0: rdata_d = duty_rb[0];
                `TMH_ADDR_DUTY1: rdata_d = duty_rb[1];
                default: rdata_d = `TMH_ZERO8;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            mode_q[0] <= `TMH_RESET_VAL;
            mode_q[1] <= `TMH_RESET_VAL;
            period_q[0] <= `TMH_RESET_VAL;
            period_q[1] <= `TMH_RESET_VAL;
            rdata_q <= `TMH_ZERO8;
        end else begin
            mode_q <= mode_d;
            period_q <= period_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // prescaler and clock source edges
    // ------------------------------------------------------------
    logic [`TMH_PRE_W-1:0] pre_q, pre_d;
    logic [`TMH_LSO_W-1:0] lso_div_q, lso_div_d;
    logic lso_prev_q, lso_prev_d;
    logic ev_prev_q, ev_prev_d;
    logic lso_rise, ev_rise;

    assign lso_rise = lso_clk && !lso_prev_q;
    // event counter output used directly, its pin need not drive
    assign ev_rise = event_counter_out && !ev_prev_q;

    always_comb begin
        pre_d = pre_q + `TMH_PRE_ONE;
        lso_div_d = lso_rise ? lso_div_q + `TMH_LSO_ONE : lso_div_q;
        lso_prev_d = lso_clk;
        ev_prev_d = event_counter_out;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pre_q <= `TMH_PRE_ZERO;
            lso_div_q <= `TMH_LSO_ZERO;
            lso_prev_q <= 1'b0;
            ev_prev_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            lso_div_q <= lso_div_d;
            lso_prev_q <= lso_prev_d;
            ev_prev_q <= ev_prev_d;
        end
    end

    // one-cycle enables for each divide ratio
    logic div2, div4, div16, div64, div1k, div4k, lso128, lso512;
    assign div2 = &pre_q[0:0];
    assign div4 = &pre_q[1:0];
    assign div16 = &pre_q[3:0];
    assign div64 = &pre_q[5:0];
    assign div1k = &pre_q[9:0];
    assign div4k = &pre_q[11:0];
    assign lso128 = lso_rise && (&lso_div_q[6:0]);
    assign lso512 = lso_rise && (&lso_div_q[8:0]);

    // ------------------------------------------------------------
    // count clock selection
    // ------------------------------------------------------------
    logic [2:0] cks0, cks1;
    assign cks0 = mode_q[0][`TMH_CKS_HI:`TMH_CKS_LO];
    assign cks1 = mode_q[1][`TMH_CKS_HI:`TMH_CKS_LO];

    always_comb begin
        unique case (cks0)
            `TMH_CKS_DIV1: tick[0] = 1'b1;
            `TMH_CKS_C1: tick[0] = div2;
            `TMH_CKS_C2: tick[0] = div4;
            `TMH_CKS_C3: tick[0] = div64;
            `TMH_CKS_C4: tick[0] = div1k;
            `TMH_CKS_C5: tick[0] = ev_rise;
            default: tick[0] = 1'b0;
        endcase
    end

    always_comb begin
        unique case (cks1)
            `TMH_CKS_DIV1: tick[1] = 1'b1;
            `TMH_CKS_C1: tick[1] = div4;
            `TMH_CKS_C2: tick[1] = div16;
            `TMH_CKS_C3: tick[1] = div64;
            `TMH_CKS_C4: tick[1] = div4k;
            `TMH_CKS_C5: tick[1] = lso128;
            `TMH_CKS_C6: tick[1] = lso512;
            `TMH_CKS_C7: tick[1] = lso_rise;
        endcase
    end

    // ------------------------------------------------------------
    // timer channels
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_ch
        tmh_channel #(
            .HAS_CARRIER(i == 1)
        ) u_ch (
            .clk(clk),
            .resetn(resetn),
            .count_tick(tick[i]),
            .run_en(mode_q[i][`TMH_RUN_BIT]),
            .op_mode(mode_q[i][`TMH_MODE_HI:`TMH_MODE_LO]),
            .idle_level(mode_q[i][`TMH_IDLE_BIT]),
            .out_en(mode_q[i][`TMH_OEN_BIT]),
            .period_compare(period_q[i]),
            .duty_wr(duty_wr[i]),
            .duty_wdata(reg_wdata),
            .duty_readback(duty_rb[i]),
            .irq(irq[i]),
            .timer_out(tout[i])
        );
    end

    assign timer_output_pin0 = tout[0];
    assign timer_output_pin1 = tout[1];
    assign timer_interrupt_request0 = irq[0];
    assign timer_interrupt_request1 = irq[1];

endmodule : tmh_top

//--- tmh_regs.svh
// register map, field positions and timing constants of the timer pair
`ifndef TMH_REGS_SVH
`define TMH_REGS_SVH

`define TMH_ADDR_PERIOD0 16'hff18
`define TMH_ADDR_PERIOD1 16'hff1a
`define TMH_ADDR_DUTY0 16'hff19
`define TMH_ADDR_DUTY1 16'hff1b
`define TMH_ADDR_MODE0 16'hff69
`define TMH_ADDR_MODE1 16'hff6c

`define TMH_RESET_VAL 8'h00
`define TMH_ZERO8 8'h00
`define TMH_ONE8 8'h01

`define TMH_RUN_BIT 7
`define TMH_CKS_HI 6
`define TMH_CKS_LO 4
`define TMH_MODE_HI 3
`define TMH_MODE_LO 2
`define TMH_IDLE_BIT 1
`define TMH_OEN_BIT 0

`define TMH_MODE_INTERVAL 2'b00
`define TMH_MODE_CARRIER 2'b01
`define TMH_MODE_PWM 2'b10

`define TMH_PRE_W 12
`define TMH_PRE_ZERO 12'h000
`define TMH_PRE_ONE 12'h001
`define TMH_LSO_W 9
`define TMH_LSO_ZERO 9'h000
`define TMH_LSO_ONE 9'h001

`define TMH_CKS_DIV1 3'h0
`define TMH_CKS_C1 3'h1
`define TMH_CKS_C2 3'h2
`define TMH_CKS_C3 3'h3
`define TMH_CKS_C4 3'h4
`define TMH_CKS_C5 3'h5
`define TMH_CKS_C6 3'h6
`define TMH_CKS_C7 3'h7

`endif

//--- tmh_pkg.sv
// types shared by the timer pair
package tmh_pkg;

typedef enum logic {
    TMH_SEL_PERIOD,
    TMH_SEL_DUTY
} tmh_cmp_sel_t;

endpackage : tmh_pkg

//--- tmh_channel.sv
// one 8-bit compare timer channel: counter, compare, duty buffer, output
`timescale 1ns/10ps
`include "tmh_regs.svh"

module tmh_channel #(
    parameter bit HAS_CARRIER = 1'b0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic count_tick,
    input wire logic run_en,
    input wire logic [1:0] op_mode,
    input wire logic idle_level,
    input wire logic out_en,
    input wire logic [7:0] period_compare,
    input wire logic duty_wr,
    input wire logic [7:0] duty_wdata,
    output logic [7:0] duty_readback,
    output logic irq,
    output logic timer_out
);

    logic [7:0] cnt_q, cnt_d;
    logic [7:0] duty_act_q, duty_act_d;
    logic [7:0] duty_buf_q, duty_buf_d;
    logic pend_q, pend_d;
    logic tff_q, tff_d;
    logic irq_q, irq_d;
    tmh_pkg::tmh_cmp_sel_t sel_q, sel_d;
    logic is_pwm, is_car, per_hit, duty_hit;

    assign is_pwm = (op_mode == `TMH_MODE_PWM);
    assign is_car = HAS_CARRIER && (op_mode == `TMH_MODE_CARRIER);
    // duty register only compared in pwm/carrier while selected
    assign per_hit = (cnt_q == period_compare) && ((!is_pwm && !is_car) ||
                     sel_q == tmh_pkg::TMH_SEL_PERIOD);
    assign duty_hit = (is_pwm || is_car) && sel_q == tmh_pkg::TMH_SEL_DUTY &&
                      (cnt_q == duty_act_q);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        duty_act_d = duty_act_q;
        duty_buf_d = duty_buf_q;
        pend_d = pend_q;
        tff_d = tff_q;
        irq_d = 1'b0;
        sel_d = sel_q;
        if (!run_en) begin
            cnt_d = `TMH_ZERO8;
            tff_d = idle_level;
            sel_d = tmh_pkg::TMH_SEL_PERIOD;
            if (duty_wr) begin
                duty_act_d = duty_wdata;
                duty_buf_d = duty_wdata;
                pend_d = 1'b0;
            end
        end else begin
            if (duty_wr) begin
                duty_buf_d = duty_wdata;
                pend_d = 1'b1;
            end
            if (count_tick) begin
                cnt_d = cnt_q + `TMH_ONE8;
                if (per_hit) begin
                    cnt_d = `TMH_ZERO8;
                    irq_d = 1'b1;
                    tff_d = ~tff_q;
                    sel_d = tmh_pkg::TMH_SEL_DUTY;
                end else if (duty_hit) begin
                    tff_d = ~tff_q;
                    sel_d = tmh_pkg::TMH_SEL_PERIOD;
                    if (is_car) begin
                        cnt_d = `TMH_ZERO8;
                        irq_d = 1'b1;
                    end
                    if (pend_q && !duty_wr) begin
                        duty_act_d = duty_buf_q;
                        pend_d = 1'b0;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_q <= `TMH_ZERO8;
            duty_act_q <= `TMH_RESET_VAL;
            duty_buf_q <= `TMH_RESET_VAL;
            pend_q <= 1'b0;
            tff_q <= 1'b0;
            irq_q <= 1'b0;
            sel_q <= tmh_pkg::TMH_SEL_PERIOD;
        end else begin
            cnt_q <= cnt_d;
            duty_act_q <= duty_act_d;
            duty_buf_q <= duty_buf_d;
            pend_q <= pend_d;
            tff_q <= tff_d;
            irq_q <= irq_d;
            sel_q <= sel_d;
        end
    end

    assign duty_readback = duty_buf_q;
    assign irq = irq_q;
    // idle level whenever output disabled
    assign timer_out = out_en ? tff_q : idle_level;

endmodule : tmh_channel

//--- tmh_top_props.sv
// port assertions of the timer pair
`timescale 1ns/10ps
module tmh_top_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic timer_output_pin0,
    input wire logic timer_output_pin1,
    input wire logic timer_interrupt_request0,
    input wire logic timer_interrupt_request1
);
// ---
// shadow of timer zero settings
// ---
logic [7:0] mode0_q;
logic [7:0] per0_q;
logic w_m0;
logic w_m1;
assign w_m0 = reg_wr && reg_addr == 16'hff69;
assign w_m1 = reg_wr && reg_addr == 16'hff6c;
always_ff @(posedge clk) begin
    if (!resetn) begin
        mode0_q <= 8'h00;
        per0_q <= 8'h00;
    end else begin
        if (w_m0) begin
            mode0_q <= reg_wdata;
        end
        if (reg_wr && reg_addr == 16'hff18) begin
            per0_q <= reg_wdata;
        end
    end
end
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
a_rdata_reset: assert property (disable iff (1'b0) !resetn |=> reg_rdata == 8'h00)
    else $error("read data not cleared by reset");
a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
a_mode_rd: assert property (reg_rd && reg_addr == 16'hff69 |=> reg_rdata == $past(mode0_q))
    else $error("mode read differs from last write");
a_unmapped_rd: assert property (reg_rd && !(reg_addr inside {16'hff18, 16'hff19,
    16'hff1a, 16'hff1b, 16'hff69, 16'hff6c}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
a_idle_lvl0: assert property (w_m0 && !(reg_wdata[7] && reg_wdata[0]) ##1 !w_m0
    |=> timer_output_pin0 == $past(reg_wdata[1], 2))
    else $error("timer0 pin not at idle level");
a_idle_lvl1: assert property (w_m1 && !(reg_wdata[7] && reg_wdata[0]) ##1 !w_m1
    |=> timer_output_pin1 == $past(reg_wdata[1], 2))
    else $error("timer1 pin not at idle level");
a_stop_quiet: assert property (w_m0 && !reg_wdata[7] ##1 !w_m0
    |=> !timer_interrupt_request0 [*3])
    else $error("timer0 interrupt after stop");
a_irq_gap: assert property (timer_interrupt_request0 && mode0_q == 8'h81
    && per0_q == 8'h03 |=> !timer_interrupt_request0 [*3]
    ##1 (timer_interrupt_request0 || !mode0_q[7]))
    else $error("timer0 interval not four ticks");
a_pin_flip: assert property (timer_interrupt_request0 && mode0_q[7] && mode0_q[0]
    |-> timer_output_pin0 != $past(timer_output_pin0))
    else $error("timer0 pin did not toggle on match");
c_irq0: cover property (timer_interrupt_request0);
c_carrier: cover property (timer_interrupt_request1 ##2 timer_interrupt_request1);
c_mode_rd: cover property (reg_rd && reg_addr == 16'hff69);
endmodule : tmh_top_chk

bind tmh_top tmh_top_chk tmh_top_chk_i (
    .clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .timer_output_pin0, .timer_output_pin1,
    .timer_interrupt_request0, .timer_interrupt_request1
);

//--- tmh_top_tb.sv
// self-checking bench of the timer pair
`timescale 1ns/10ps
module tmh_top_tb;
logic clk, resetn, reg_wr, reg_rd, lso_clk, event_counter_out, pin0, pin1, irq0, irq1;
logic [15:0] reg_addr;
logic [7:0] reg_wdata, reg_rdata;
int error_cnt = 0;
int n_compared = 0;
tmh_top tmh_top_i (.clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .lso_clk, .event_counter_out, .timer_output_pin0(pin0), .timer_output_pin1(pin1),
    .timer_interrupt_request0(irq0), .timer_interrupt_request1(irq1));
// ---
// clocks and helpers
// ---
initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
end
always @(posedge clk) begin
    lso_clk <= ~lso_clk;
    event_counter_out <= ~event_counter_out;
end
task automatic give_verdict();
    if (error_cnt == 0 && n_compared > 0) begin
        $display("Finished cleanly");
    end else begin
        $display("Finished with errors");
    end
    $finish;
endtask : give_verdict
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
        error_cnt++;
        $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
endtask : chk
task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
endtask : wr
task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("reg_rdata", {24'h0, e}, {24'h0, reg_rdata});
endtask : rd
function automatic logic irq(input bit t);
    return t ? irq1 : irq0;
endfunction : irq
task automatic upto_irq(input bit t, output int c);
    c = 0;
    do begin
        @(negedge clk);
        c++;
    end while (irq(t) !== 1'b1 && c < 20000);
    if (irq(t) !== 1'b1) begin
        error_cnt++;
        $display("[FAIL] irq wait expected pulse seen none");
        give_verdict();
    end
endtask : upto_irq
// ---
// scenarios
// ---
task automatic t_regs();
    logic [15:0] a [6] = '{16'hff18, 16'hff19, 16'hff1a, 16'hff1b, 16'hff69, 16'hff6c};
    for (int i = 0; i < 6; i++) rd(a[i], 8'h00);
    for (int i = 0; i < 6; i++) wr(a[i], 8'h5c + 8'(i));
    for (int i = 0; i < 6; i++) rd(a[i], 8'h5c + 8'(i));
    rd(16'hff00, 8'h00);
    wr(16'hff69, 8'h00);
    wr(16'hff6c, 8'h00);
endtask : t_regs
task automatic t_interval();
    int g;
    wr(16'hff19, 8'h01);
    wr(16'hff18, 8'h03);
    wr(16'hff69, 8'h81);
    upto_irq(1'b0, g);
    chk("pin0 first", 1, pin0);
    upto_irq(1'b0, g);
    chk("interval gap", 4, g);
    chk("pin0 second", 0, pin0);
    upto_irq(1'b0, g);
    chk("pin0 third", 1, pin0);
    wr(16'hff69, 8'h01);
    repeat (2) @(negedge clk);
    chk("pin0 stop idle", 0, pin0);
    wr(16'hff69, 8'h02);
    repeat (10) @(negedge clk);
    chk("irq0 stopped", 0, irq0);
    chk("pin0 stopped", 1, pin0);
    wr(16'hff69, 8'h82);
    upto_irq(1'b0, g);
    chk("pin0 disabled", 1, pin0);
    wr(16'hff69, 8'h00);
    repeat (2) @(negedge clk);
    chk("pin0 idle low", 0, pin0);
endtask : t_interval
task automatic t_clk_sel();
    int g;
    int d0 [6] = '{1, 2, 4, 64, 1024, 2};
    int d1 [8] = '{1, 4, 16, 64, 4096, 256, 1024, 2};
    wr(16'hff18, 8'h01);
    wr(16'hff1a, 8'h01);
    for (int i = 0; i < 8; i++) begin
        if (i < 6) begin
            wr(16'hff69, 8'h80 | 8'(i << 4));
            upto_irq(1'b0, g);
            upto_irq(1'b0, g);
            chk("timer0 gap", 2 * d0[i], g);
            wr(16'hff69, 8'h00);
        end
        wr(16'hff6c, 8'h80 | 8'(i << 4));
        upto_irq(1'b1, g);
        upto_irq(1'b1, g);
        chk("timer1 gap", 2 * d1[i], g);
        wr(16'hff6c, 8'h00);
    end
endtask : t_clk_sel
task automatic pwm_chk(input int w);
    int g;
    upto_irq(1'b1, g);
    for (int k = 0; k < 6; k++) begin
        chk("pwm pin", k < w, pin1);
        chk("pwm irq", k == 0, irq1);
        @(negedge clk);
    end
    chk("pwm irq", 1, irq1);
endtask : pwm_chk
task automatic t_pwm();
    wr(16'hff1a, 8'h05);
    wr(16'hff1b, 8'h02);
    wr(16'hff6c, 8'h89);
    pwm_chk(3);
    wr(16'hff1b, 8'h01);
    @(negedge clk);
    chk("pwm old duty", 1, pin1);
    pwm_chk(2);
    wr(16'hff6c, 8'h00);
endtask : t_pwm
task automatic t_carrier();
    int g;
    wr(16'hff1a, 8'h03);
    wr(16'hff1b, 8'h01);
    wr(16'hff6c, 8'h85);
    upto_irq(1'b1, g);
    upto_irq(1'b1, g);
    chk("carrier duty gap", 2, g);
    upto_irq(1'b1, g);
    chk("carrier period gap", 4, g);
    wr(16'hff6c, 8'h00);
endtask : t_carrier
initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    lso_clk = 1'b0;
    event_counter_out = 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_interval();
    t_clk_sel();
    t_pwm();
    t_carrier();
    give_verdict();
end
endmodule : tmh_top_tb
